// *** logic/ssw_pkg.sv ***
// Function
// - Supply below threshold holds reset asserted: both outputs in dual variant, low output only with watchdog.
// - After supply recovers, hold reset 200 ms, then release.
// - External low on reset pin starts reset, with full release timeout.
// - Either edge of watchdog toggle input restarts the watchdog timer.
// - No toggle edge within 1.6 s asserts reset; host must toggle.
// - Aux low indicator low while aux sense below reference or rst is high, else high.
// - Memory writes inhibited while supply below threshold, including power-up.
// - Variant parameter: dual reset outputs no watchdog, or low output plus watchdog.
package ssw_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RELEASE_MS = 200;
  localparam int unsigned WDOG_MS = 1600;
  localparam int unsigned RELEASE_CYC = CLK_HZ / 1000 * RELEASE_MS;
  localparam int unsigned WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
  localparam int CNT_W = 32;
  // ==========================================================
  // Variants
  localparam bit VAR_DUAL = 1'b0;
  localparam bit VAR_WDOG = 1'b1;
  typedef enum logic [0:0] {SSW_HOLD, SSW_RUN} ssw_state_e;
endpackage

// *** logic/ssw_top.sv ***
`timescale 1ns/1ps
module ssw_top
  import ssw_pkg::*;
#(
  parameter bit VARIANT = VAR_DUAL,
  parameter int unsigned RELEASE_LIMIT = RELEASE_CYC,
  parameter int unsigned WDOG_LIMIT = WDOG_CYC
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic rst, // Sync reset, high
  input wire logic supply_low, // Main supply below threshold
  input wire logic aux_sense_in, // High while aux below reference
  input wire logic reset_n_in, // Sensed level of reset pin
  input wire logic watchdog_toggle_in, // Host toggle
  output logic reset_n_out, // Drive value of reset pin (0)
  output logic reset_n_oe, // Enable, low while pulling low
  output logic reset_hi, // Active-high reset output
  output logic aux_low_n, // Aux low indicator
  output logic write_inhibit // Memory write block
);
  // ==========================================================
  // Cause detection
  ssw_state_e state;
  logic [CNT_W-1:0] hold_cnt;
  logic wdi_prev;
  logic kick;
  logic wd_expired;
  logic ext_pull;
  logic cause;

  // Reset stands while holding or while a cause is live
  function automatic logic asserted_now(input ssw_state_e s, input logic c);
    return s == SSW_HOLD || c;
  endfunction

  // Own drive excluded so the pin does not latch itself low
  assign ext_pull = !reset_n_in && reset_n_oe;
  assign kick = (VARIANT == VAR_WDOG) && (watchdog_toggle_in != wdi_prev);
  assign cause = supply_low || ext_pull ||
                 ((VARIANT == VAR_WDOG) && wd_expired);

  always_ff @(posedge mclk) begin
    if (rst) begin
      wdi_prev <= 1'b0;
    end else begin
      wdi_prev <= watchdog_toggle_in;
    end
  end

  ssw_wdog #(.LIMIT(WDOG_LIMIT)) u_wdog (
    .mclk(mclk),
    .rst(rst),
    .enable((VARIANT == VAR_WDOG) && state == SSW_RUN),
    .kick(kick),
    .expired(wd_expired)
  );

  // ==========================================================
  // Reset sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SSW_HOLD;
      hold_cnt <= '0;
    end else begin
      unique case (state)
        SSW_HOLD: begin
          if (cause) begin
            hold_cnt <= '0;
          end else if (hold_cnt == CNT_W'(RELEASE_LIMIT - 1)) begin
            state <= SSW_RUN;
            hold_cnt <= '0;
          end else begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
        SSW_RUN: begin
          if (cause) begin
            state <= SSW_HOLD;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs, all registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_n_out <= 1'b0;
      reset_n_oe <= 1'b0;
      // Watchdog variant has no high output, so it stays low even here
      reset_hi <= (VARIANT == VAR_DUAL);
    end else begin
      reset_n_out <= 1'b0;
      reset_n_oe <= !asserted_now(state, cause);
      // Variant without the high output keeps it parked low
      reset_hi <= (VARIANT == VAR_DUAL) && asserted_now(state, cause);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aux_low_n <= 1'b0;
      write_inhibit <= 1'b1;
    end else begin
      aux_low_n <= !aux_sense_in;
      write_inhibit <= supply_low;
    end
  end

  // ==========================================================
  // Checks
  default clocking chk_clk @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Supply fault path
  chk_supply_holds: assert property (
    supply_low |=> !reset_n_oe)
    else $error("reset not driven during supply fault");

  chk_supply_hi: assert property (
    supply_low && (VARIANT == VAR_DUAL) |=> reset_hi)
    else $error("high reset not driven during supply fault");

  chk_supply_state: assert property (
    supply_low |=> state == SSW_HOLD)
    else $error("sequencer left hold during supply fault");

  chk_hold_drives: assert property (
    state == SSW_HOLD |=> !reset_n_oe)
    else $error("reset pin released while holding");

  // Release timeout
  chk_release_end: assert property (
    state == SSW_HOLD && !cause && hold_cnt == CNT_W'(RELEASE_LIMIT - 1)
    |=> state == SSW_RUN)
    else $error("release not taken");

  chk_hold_early: assert property (
    state == SSW_HOLD && hold_cnt != CNT_W'(RELEASE_LIMIT - 1)
    |=> state == SSW_HOLD)
    else $error("release taken before the timeout");

  chk_hold_counts: assert property (
    state == SSW_HOLD && !cause && hold_cnt != CNT_W'(RELEASE_LIMIT - 1)
    |=> hold_cnt == $past(hold_cnt) + 1'b1)
    else $error("release counter did not advance");

  chk_release_len: assert property (
    $rose(state == SSW_RUN) |-> $past(hold_cnt) == CNT_W'(RELEASE_LIMIT - 1))
    else $error("run entered with a short timeout");

  chk_run_releases: assert property (
    state == SSW_RUN && !cause |=> reset_n_oe)
    else $error("reset pin still driven in run");

  chk_oe_rise: assert property (
    $rose(reset_n_oe) |-> $past(state) == SSW_RUN)
    else $error("reset pin released outside run");

  // Reset pin as input
  chk_pull_holds: assert property (
    ext_pull |=> state == SSW_HOLD)
    else $error("manual pull ignored");

  chk_pin_low: assert property (
    reset_n_out == 1'b0)
    else $error("reset pin drive value not low");

  chk_own_drive: assert property (
    !reset_n_oe |-> !ext_pull)
    else $error("own drive seen as a manual pull");

  // Watchdog
  chk_wd_reset: assert property (
    wd_expired |=> state == SSW_HOLD ##1 !reset_n_oe)
    else $error("watchdog expiry did not reset");

  chk_wd_run: assert property (
    wd_expired |-> $past(state) == SSW_RUN)
    else $error("watchdog expired outside run");

  chk_hold_no_wd: assert property (
    state == SSW_HOLD |=> !wd_expired)
    else $error("watchdog active while reset held");

  chk_dual_no_kick: assert property (
    (VARIANT == VAR_DUAL) |-> !kick)
    else $error("kick seen on variant without watchdog");

  // Aux indicator and write inhibit
  chk_aux_follows: assert property (
    aux_sense_in |=> !aux_low_n)
    else $error("aux indicator not low");

  chk_aux_clear: assert property (
    !aux_sense_in |=> aux_low_n)
    else $error("aux indicator not released");

  chk_wr_inhibit: assert property (
    supply_low |=> write_inhibit)
    else $error("writes not inhibited");

  chk_wr_release: assert property (
    !supply_low |=> !write_inhibit)
    else $error("writes still inhibited");

  // Restart of the timeout
  chk_cause_restart: assert property (
    cause |=> state == SSW_HOLD && hold_cnt == '0)
    else $error("timeout not restarted");

  chk_pull_restart: assert property (
    ext_pull |=> hold_cnt == '0)
    else $error("manual pull did not restart timeout");

  chk_wd_restart: assert property (
    wd_expired |=> hold_cnt == '0)
    else $error("watchdog expiry did not restart timeout");

  chk_run_idle: assert property (
    state == SSW_RUN |-> hold_cnt == '0)
    else $error("release counter not cleared in run");

  // Variant outputs
  chk_hi_variant: assert property (
    (VARIANT == VAR_WDOG) |-> !reset_hi)
    else $error("high reset driven on watchdog variant");

  chk_hi_match: assert property (
    reset_hi == ((VARIANT == VAR_DUAL) && !reset_n_oe))
    else $error("high and low reset outputs disagree");
endmodule

// *** logic/ssw_wdog.sv ***
`timescale 1ns/1ps
module ssw_wdog
  import ssw_pkg::*;
#(
  parameter int unsigned LIMIT = WDOG_CYC
) (
  input wire logic mclk, // Clock
  input wire logic rst, // Sync reset
  input wire logic enable, // Count allowed
  input wire logic kick, // Restart pulse
  output logic expired // One-cycle timeout pulse
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge mclk) begin
    if (rst || !enable || kick) begin
      count <= '0;
      expired <= 1'b0;
    end else if (count == CNT_W'(LIMIT - 1)) begin
      count <= '0;
      expired <= 1'b1;
    end else begin
      count <= count + 1'b1;
      expired <= 1'b0;
    end
  end

  chk_kick_clears: assert property (@(posedge mclk) disable iff (rst)
    kick |=> !expired)
    else $error("watchdog expired right after a kick");
endmodule

// *** sim/ssw_host.sv ***
`timescale 1ns/1ps
// ==========
// Host side: pin pull-up, push-button, toggle
module ssw_host (
  input wire logic mclk, // Clock
  input wire logic reset_n_oe, // Device pin enable
  input wire logic press, // Button held
  input wire logic kick_en, // Software alive
  output logic reset_n_in, // Pin level
  output logic watchdog_toggle_in // Toggle
);
  logic [1:0] div = 2'h0;
  logic tog = 1'b0;
  // Pull-up wins unless someone pulls low
  assign reset_n_in = reset_n_oe & ~press;
  assign watchdog_toggle_in = tog;
  // Rising edge so the bench's falling-edge kick_en never races it
  always @(posedge mclk) begin
    if (kick_en) begin
      div <= div + 2'h1;
      // Every 4 cycles, well inside the timeout
      if (div == 2'h3) begin
        tog <= ~tog;
      end
    end
  end
endmodule

// *** sim/ssw_top_bench.sv ***
`timescale 1ns/1ps
module ssw_top_bench;
  import ssw_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sup = 1'b0;
  logic aux = 1'b0;
  logic press = 1'b0;
  logic kick_en = 1'b1;
  logic pin_u, tog, oe_u, oe_d, hi_u, hi_d, aux_n, wi, drv_u;
  int n_errors = 0;
  int tests_run = 0;
  always #20 mclk = ~mclk;
  ssw_host host_u (.mclk(mclk), .reset_n_oe(oe_u), .press(press),
    .kick_en(kick_en), .reset_n_in(pin_u), .watchdog_toggle_in(tog));
  ssw_top #(.VARIANT(VAR_WDOG), .RELEASE_LIMIT(20), .WDOG_LIMIT(30)) dut_u (
    .mclk(mclk), .rst(rst), .supply_low(sup), .aux_sense_in(aux),
    .reset_n_in(pin_u), .watchdog_toggle_in(tog), .reset_n_out(drv_u),
    .reset_n_oe(oe_u), .reset_hi(hi_u), .aux_low_n(aux_n),
    .write_inhibit(wi));
  ssw_top #(.VARIANT(VAR_DUAL), .RELEASE_LIMIT(20), .WDOG_LIMIT(30)) dut_d (
    .mclk(mclk), .rst(rst), .supply_low(sup), .aux_sense_in(aux),
    .reset_n_in(oe_d & ~press), .watchdog_toggle_in(tog), .reset_n_out(),
    .reset_n_oe(oe_d), .reset_hi(hi_d), .aux_low_n(), .write_inhibit());
  // ==========
  // Shared helpers
  task automatic chk(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk_rst(input logic on);
    chk("oe_u", ~on, oe_u);
    chk("oe_d", ~on, oe_d);
    chk("hi_d", on, hi_d);
    chk("hi_u", 1'b0, hi_u);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic supply_fault;
    sup = 1'b1;
    cyc(3);
    chk_rst(1'b1);
    chk("write_inhibit", 1'b1, wi);
    sup = 1'b0;
    cyc(12);
    chk_rst(1'b1);
    chk("write_inhibit", 1'b0, wi);
    cyc(14);
    chk_rst(1'b0);
  endtask
  task automatic glitch_restart;
    sup = 1'b1;
    cyc(1);
    sup = 1'b0;
    cyc(15);
    sup = 1'b1;
    cyc(1);
    sup = 1'b0;
    cyc(15);
    chk_rst(1'b1);
    cyc(11);
    chk_rst(1'b0);
  endtask
  task automatic manual_press;
    press = 1'b1;
    cyc(3);
    press = 1'b0;
    cyc(12);
    chk_rst(1'b1);
    cyc(14);
    chk_rst(1'b0);
  endtask
  task automatic aux_follow;
    aux = 1'b1;
    cyc(2);
    chk("aux_low_n", 1'b0, aux_n);
    aux = 1'b0;
    cyc(2);
    chk("aux_low_n", 1'b1, aux_n);
  endtask
  task automatic wdog_expire;
    kick_en = 1'b0;
    cyc(15);
    chk("oe_u", 1'b1, oe_u);
    cyc(23);
    chk("oe_u", 1'b0, oe_u);
    chk("oe_d", 1'b1, oe_d);
    kick_en = 1'b1;
    cyc(40);
    chk("oe_u", 1'b1, oe_u);
  endtask
  // Reset again in mid-run: outputs return to reset, full timeout follows
  task automatic mid_reset;
    rst = 1'b1;
    cyc(2);
    chk_rst(1'b1);
    chk("write_inhibit", 1'b1, wi);
    rst = 1'b0;
    cyc(19);
    chk_rst(1'b1);
    cyc(3);
    chk_rst(1'b0);
    chk("reset_n_out", 1'b0, drv_u);
  endtask
  initial begin
    cyc(20);
    chk_rst(1'b1);
    rst = 1'b0;
    cyc(25);
    chk_rst(1'b0);
    chk("reset_n_out", 1'b0, drv_u);
    supply_fault();
    glitch_restart();
    manual_press();
    aux_follow();
    wdog_expire();
    mid_reset();
    tally_and_finish();
  end
  initial begin
    #80000;
    n_errors++;
    tally_and_finish();
  end
endmodule
